// ==== adc_conversion_control.sv ====
// Conversion sequencer, control registers and result formatting.
// Assumes the SAR core returns an offset-binary code at the last tick.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module adc_conversion_control (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Register port
  input wire logic [adc_ctrl_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [adc_ctrl_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [adc_ctrl_pkg::DATA_W-1:0] RDATA_O,
  // Trigger sources
  input wire logic EXTERNAL_TRIGGER_PIN_N_I,
  input wire logic LOGIC_ARRAY_TRIGGER_I,
  input wire logic FIRST_GENERAL_TIMER_I,
  input wire logic SECOND_GENERAL_TIMER_I,
  // Converter core
  input wire logic [adc_ctrl_pkg::CODE_W-1:0] CORE_CODE_I,
  output logic POWER_UP_O,
  output logic [1:0] MODE_O,
  output logic [adc_ctrl_pkg::CHAN_W-1:0] CHANNEL_O,
  output logic ACQUIRE_O,
  output logic CONVERT_O,
  output logic CONV_TICK_O,
  // Status pins
  output logic CONVERTER_ACTIVE_PIN_O,
  output logic RESULT_READY_O
);
  import adc_ctrl_pkg::*;

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ctrl;
    logic [4:0] chan;
    state_t state;
    logic [2:0] div_code;
    logic [4:0] acq_len;
    logic [4:0] div_cnt;
    logic [4:0] step;
    logic [5:0] tick_cnt;
    logic [1:0] mode;
    logic single;
    logic cont;
    logic [1:0] ext_sync;
    logic ext_prev;
    logic [9:0] pwr_cnt;
    logic [31:0] rdata;
  } st_t;

  st_t q;
  st_t d;

  logic [2:0] ctype;
  logic is_temp;
  logic [2:0] div_prog;
  logic [2:0] div_sel;
  logic [4:0] acq_sel;
  logic [4:0] div_lim;
  logic tick;
  logic ext_fall;
  logic src;
  logic trig;
  logic start;
  logic push;
  logic pop;
  logic busy;
  logic settled;
  logic [11:0] code_fmt;
  logic [15:0] res_word;
  logic f_ready;
  logic f_valid;
  logic [15:0] f_data;

  // -------------------------------------------------------------------
  // Settings
  // -------------------------------------------------------------------
  assign ctype = q.ctrl[TYPE_LSB +: 3];
  assign is_temp = q.chan == TEMP_CHAN;
  // Reserved divider codes fall back to the slowest rate
  assign div_prog = (q.ctrl[CLK_LSB +: 3] > DIV_MAX) ? DIV_MAX
                    : q.ctrl[CLK_LSB +: 3];
  assign div_sel = is_temp ? TEMP_DIV : div_prog;
  assign acq_sel = is_temp ? TEMP_ACQ
                   : 5'(ACQ_BASE << q.ctrl[ACQ_LSB +: 2]);
  // Code 000 ticks every clock, for full rate at the top clock
  assign div_lim = 5'((6'h01 << q.div_code) - 6'h01);
  assign tick = (q.state != S_IDLE) && (q.div_cnt == div_lim);
  assign busy = q.state != S_IDLE;
  assign settled = q.pwr_cnt == PWR_SETTLE_CYC;

  // -------------------------------------------------------------------
  // Triggers
  // -------------------------------------------------------------------
  // Pin is asynchronous; only the second stage is looked at
  assign ext_fall = q.ext_prev && !q.ext_sync[1];
  assign src = (ctype == TYPE_EXT) ? ext_fall
             : (ctype == TYPE_T1) ? SECOND_GENERAL_TIMER_I
             : (ctype == TYPE_T0) ? FIRST_GENERAL_TIMER_I
             : (ctype == TYPE_PLA) ? LOGIC_ARRAY_TRIGGER_I
             : (ctype == TYPE_SINGLE) || (ctype == TYPE_CONT);
  // Continuous mode keeps running with the start enable cleared
  assign trig = (q.ctrl[START_BIT] && src) || q.cont;
  // A full FIFO holds off new starts rather than drop results
  assign start = (q.state == S_IDLE) && q.ctrl[PWR_BIT] && f_ready
                 && trig;

  // -------------------------------------------------------------------
  // Result format
  // -------------------------------------------------------------------
  assign code_fmt = (q.mode == MODE_DIFF) ? (CORE_CODE_I ^ DIFF_FLIP)
                    : CORE_CODE_I;
  assign res_word = (q.mode == MODE_DIFF)
                    ? {{4{code_fmt[11]}}, code_fmt}
                    : {4'h0, code_fmt};
  assign push = (q.state == S_CONV) && tick && (q.step == CONV_LAST);
  assign pop = RD_I && (ADDR_I == DATA_ADDR) && f_valid;

  result_fifo #(
    .WIDTH(RES_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .in_valid_i(push),
    .in_ready_o(f_ready),
    .in_data_i(res_word),
    .out_valid_o(f_valid),
    .out_ready_i(pop),
    .out_data_o(f_data)
  );

  // -------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.ext_sync = {q.ext_sync[0], EXTERNAL_TRIGGER_PIN_N_I};
    d.ext_prev = q.ext_sync[1];
    if (!q.ctrl[PWR_BIT])
      d.pwr_cnt = '0;
    else if (!settled)
      d.pwr_cnt = q.pwr_cnt + 10'h001;
    if ((ctype != TYPE_CONT) || !q.ctrl[PWR_BIT])
      d.cont = 1'b0;
    if (busy)
      d.div_cnt = tick ? 5'h00 : q.div_cnt + 5'h01;
    // Counted apart from the step field so the length check stands alone
    if (tick)
      d.tick_cnt = q.tick_cnt + 6'h01;
    case (q.state)
      S_IDLE:
      begin
        if (start)
        begin
          d.state = S_ACQ;
          d.step = 5'h00;
          d.tick_cnt = 6'h00;
          d.div_cnt = 5'h00;
          d.div_code = div_sel;
          d.acq_len = acq_sel;
          d.mode = q.ctrl[MODE_LSB +: 2];
          d.single = ctype == TYPE_SINGLE;
          if (ctype == TYPE_CONT)
            d.cont = 1'b1;
        end
      end
      S_ACQ:
      begin
        if (tick)
        begin
          if (q.step == q.acq_len - 5'h01)
          begin
            d.state = S_CONV;
            d.step = 5'h00;
          end
          else
            d.step = q.step + 5'h01;
        end
      end
      S_CONV:
      begin
        if (tick)
        begin
          if (q.step == CONV_LAST)
          begin
            d.state = S_IDLE;
            if (q.single)
              d.ctrl[TYPE_LSB +: 3] = TYPE_EXT;
          end
          else
            d.step = q.step + 5'h01;
        end
      end
      default:
        d.state = S_IDLE;
    endcase
    // Power-down aborts a conversion in flight
    if (!q.ctrl[PWR_BIT])
      d.state = S_IDLE;
    // Register writes come last so software wins over the auto-clear
    if (WR_I && (ADDR_I == CTRL_ADDR))
      d.ctrl = WDATA_I[15:0] & CTRL_WMASK;
    if (WR_I && (ADDR_I == CHAN_ADDR))
      d.chan = WDATA_I[4:0];
    if (RD_I)
    begin
      case (ADDR_I)
        CTRL_ADDR: d.rdata = {16'h0000, q.ctrl};
        CHAN_ADDR: d.rdata = {27'h0000000, q.chan};
        STAT_ADDR: d.rdata = {29'h00000000, settled, busy, f_valid};
        DATA_ADDR: d.rdata = {f_data, 16'h0000};
        default: d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      q <= '0;
      q.ctrl <= CTRL_RESET;
      q.chan <= CHAN_RESET;
      q.state <= S_IDLE;
      q.ext_sync <= 2'h3;
      q.ext_prev <= 1'b1;
    end
    else
      q <= d;
  end

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------
  assign RDATA_O = q.rdata;
  assign POWER_UP_O = q.ctrl[PWR_BIT];
  assign MODE_O = q.ctrl[MODE_LSB +: 2];
  assign CHANNEL_O = q.chan;
  assign ACQUIRE_O = q.state == S_ACQ;
  assign CONVERT_O = q.state == S_CONV;
  assign CONV_TICK_O = tick;
  assign CONVERTER_ACTIVE_PIN_O = q.ctrl[BUSY_EN_BIT] && busy;
  assign RESULT_READY_O = f_valid;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  ctrl_reset_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    $rose(RST_N_I) |-> (q.ctrl == CTRL_RESET) && !busy)
    else $error("control reset value wrong");

  conv_length_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    push |-> (q.state == S_CONV) && (q.step == 5'h12)
             && (q.div_cnt == div_lim)
             && (q.tick_cnt == 6'(q.acq_len) + 6'h12))
    else $error("result written at wrong trial count");

  acq_length_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (q.state == S_ACQ) && q.ctrl[PWR_BIT] ##1 (q.state == S_CONV)
    |-> $past(q.step) == q.acq_len - 5'h01)
    else $error("acquisition length wrong");

  temp_override_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    start && is_temp |=> (q.div_code == 3'h5) && (q.acq_len == 5'h10))
    else $error("temperature channel override missing");

  single_clear_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    push && q.single && !(WR_I && (ADDR_I == CTRL_ADDR))
    |=> q.ctrl[2:0] == 3'h0)
    else $error("single conversion type not cleared");

  diff_format_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    push && (q.mode == MODE_DIFF)
    |-> res_word == {{4{~CORE_CODE_I[11]}}, ~CORE_CODE_I[11],
                     CORE_CODE_I[10:0]})
    else $error("differential result not twos complement");

  se_format_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    push && (q.mode != MODE_DIFF) |-> res_word == {4'h0, CORE_CODE_I})
    else $error("single-ended result not straight binary");

  data_read_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    RD_I && (ADDR_I == DATA_ADDR)
    |=> (RDATA_O[15:0] == 16'h0000) && (RDATA_O[31:16] == $past(f_data)))
    else $error("data register layout wrong");

  start_gate_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    start |-> q.ctrl[START_BIT] || q.cont)
    else $error("conversion started without enable");

  busy_pin_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    $rose(ACQUIRE_O) && q.ctrl[BUSY_EN_BIT] |-> CONVERTER_ACTIVE_PIN_O)
    else $error("busy pin not raised");

  ext_start_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (q.state == S_IDLE) && q.ctrl[PWR_BIT] && q.ctrl[START_BIT] && f_ready
    && (ctype == TYPE_EXT) && $fell(q.ext_sync[1]) |=> ACQUIRE_O)
    else $error("pin edge did not start a conversion");

  reserved_type_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    (ctype[2:1] == 2'b11) && !q.cont |-> !start)
    else $error("reserved conversion type started");

  result_room_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    push |-> f_ready)
    else $error("result written into a full buffer");

  power_abort_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    !POWER_UP_O |=> !busy && !settled)
    else $error("converter active while powered down");

  tick_spacing_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    tick && (q.div_code != 3'h0) |=> !CONV_TICK_O)
    else $error("converter clock ticks too close");

  idle_after_push_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    push |=> !busy && RESULT_READY_O)
    else $error("sequencer did not finish after result");

  single_once_a: assert property (
    @(posedge CLK_I) disable iff (!RST_N_I)
    push && q.single && !(WR_I && (ADDR_I == CTRL_ADDR))
    |=> !start || ext_fall)
    else $error("single conversion repeated");
endmodule

// ==== adc_ctrl_pkg.sv ====
// Constants, codes and types shared by the converter control block.
// Assumes a 100 MHz system clock that also serves as converter base clock.
// ---------------------------------------------------------------------
// Overview of operation
// - Three input configurations selectable by software
// - Software starts single or continuous conversions
// - Pin, logic array or timer overflows trigger
// - Temperature sensor is one extra channel
// - Single-ended and pseudo modes give straight binary
// - Differential mode gives twos complement result
// - Result at bits 27:16, sign bits above
// - Software sets clock divider and acquisition clocks
// - Reset gives eight acquisition clocks, divider two
// - Nineteen clocks follow acquisition per conversion
// - Temperature channel forces sixteen clocks, divide 32
// - Fastest settings sustain full rated throughput
// - Block is run through memory-mapped registers
// - Control register address and reset value fixed
// - Clock and acquisition field encodings
// - Conversion type codes; single returns to zero
// - Start enable gates starts; power bit settles; continuous mode here keeps restarting with the start enable cleared
// - Mode codes; busy pin enable bit
// ---------------------------------------------------------------------
package adc_ctrl_pkg;

  // -------------------------------------------------------------------
  // Widths
  // -------------------------------------------------------------------
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int CODE_W = 12;
  localparam int CHAN_W = 5;
  localparam int RES_W = 16;
  localparam int FIFO_DEPTH = 8;

  // -------------------------------------------------------------------
  // Register map
  // -------------------------------------------------------------------
  localparam logic [31:0] CTRL_ADDR = 32'hffff0500;
  localparam logic [31:0] CHAN_ADDR = 32'hffff0504;
  localparam logic [31:0] STAT_ADDR = 32'hffff050c;
  localparam logic [31:0] DATA_ADDR = 32'hffff0510;
  localparam logic [15:0] CTRL_RESET = 16'h0600;
  localparam logic [15:0] CTRL_WMASK = 16'h1fff;
  localparam logic [4:0] CHAN_RESET = 5'h00;

  // -------------------------------------------------------------------
  // Control fields
  // -------------------------------------------------------------------
  localparam int TYPE_LSB = 0;
  localparam int MODE_LSB = 3;
  localparam int PWR_BIT = 5;
  localparam int BUSY_EN_BIT = 6;
  localparam int START_BIT = 7;
  localparam int ACQ_LSB = 8;
  localparam int CLK_LSB = 10;
  localparam int RESULT_LSB = 16;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_SETTLED_BIT = 2;

  // -------------------------------------------------------------------
  // Codes
  // -------------------------------------------------------------------
  localparam logic [2:0] TYPE_EXT = 3'h0;
  localparam logic [2:0] TYPE_T1 = 3'h1;
  localparam logic [2:0] TYPE_T0 = 3'h2;
  localparam logic [2:0] TYPE_SINGLE = 3'h3;
  localparam logic [2:0] TYPE_CONT = 3'h4;
  localparam logic [2:0] TYPE_PLA = 3'h5;
  localparam logic [1:0] MODE_SE = 2'h0;
  localparam logic [1:0] MODE_DIFF = 2'h1;
  localparam logic [1:0] MODE_PSEUDO = 2'h2;
  localparam logic [2:0] DIV_MAX = 3'h5;
  localparam logic [4:0] ACQ_BASE = 5'h02;
  localparam logic [11:0] DIFF_FLIP = 12'h800;

  // -------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------
  localparam logic [4:0] CONV_LAST = 5'h12;
  localparam logic [4:0] TEMP_CHAN = 5'h10;
  localparam logic [2:0] TEMP_DIV = 3'h5;
  localparam logic [4:0] TEMP_ACQ = 5'h10;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PWR_SETTLE_NS = 5000;
  localparam logic [9:0] PWR_SETTLE_CYC =
    10'((PWR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {S_IDLE, S_ACQ, S_CONV} state_t;

endpackage

// ==== result_fifo.sv ====
// Result FIFO with valid/ready on both sides.
// Assumes DEPTH is a power of two; one clock, async active-low reset.
`timescale 1ns/1ps
module result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
  } fifo_t;

  fifo_t q;
  fifo_t d;
  logic push;
  logic pop;

  assign in_ready_o = q.cnt != (AW+1)'(DEPTH);
  assign out_valid_o = q.cnt != '0;
  assign out_data_o = q.mem[q.rd];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wr] = in_data_i;
      d.wr = q.wr + AW'(1);
    end
    if (pop)
      d.rd = q.rd + AW'(1);
    case ({push, pop})
      2'b10: d.cnt = q.cnt + (AW+1)'(1);
      2'b01: d.cnt = q.cnt - (AW+1)'(1);
      default: d.cnt = q.cnt;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q <= '0;
    else
      q <= d;
  end

  fifo_count_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!in_ready_o && !pop) |=> !in_ready_o)
    else $error("fifo lost full state");
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the converter control block.
// Assumes the package constants and a bench-driven SAR code input.
`timescale 1ns/1ps

`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("BAD %0t got %0h exp %0h", $time, got, exp); \
    end \
  end

module tb_top;
  import adc_ctrl_pkg::*;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk;
  logic rst_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [DATA_W-1:0] rdata;
  logic ext_n;
  logic logic_array_trigger;
  logic tmr0;
  logic tmr1;
  logic [CODE_W-1:0] code;
  logic pwr;
  logic [1:0] mode;
  logic [CHAN_W-1:0] chan;
  logic acq;
  logic conv;
  logic tick;
  logic active;
  logic ready;
  logic [31:0] d;
  int fails;
  int comparisons;
  // Cases: control word, core code, divider, acquisition clocks
  logic [15:0] tab_ctl [7] = '{16'h06a3, 16'h00ab, 16'h17f3, 16'h00a0,
                               16'h00b1, 16'h00ea, 16'h00a5};
  logic [11:0] tab_code [7] = '{12'h5a5, 12'h123, 12'h0ff, 12'hfff,
                                12'h7ff, 12'h800, 12'h001};
  int tab_n [7] = '{2, 1, 32, 1, 1, 1, 1};
  int tab_a [7] = '{8, 2, 16, 2, 2, 2, 2};

  adc_conversion_control dut (
    .CLK_I(clk),
    .RST_N_I(rst_n),
    .ADDR_I(addr),
    .WDATA_I(wdata),
    .WR_I(wr),
    .RD_I(rd),
    .RDATA_O(rdata),
    .EXTERNAL_TRIGGER_PIN_N_I(ext_n),
    .LOGIC_ARRAY_TRIGGER_I(logic_array_trigger),
    .FIRST_GENERAL_TIMER_I(tmr0),
    .SECOND_GENERAL_TIMER_I(tmr1),
    .CORE_CODE_I(code),
    .POWER_UP_O(pwr),
    .MODE_O(mode),
    .CHANNEL_O(chan),
    .ACQUIRE_O(acq),
    .CONVERT_O(conv),
    .CONV_TICK_O(tick),
    .CONVERTER_ACTIVE_PIN_O(active),
    .RESULT_READY_O(ready)
  );

  initial
  begin
    clk = 1'b0;
    forever
      #5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic finish_test;
    if (fails == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr_reg(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data appear in the cycle after the strobe and hold until the next read
  task automatic rd_reg(input logic [31:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  function automatic logic [15:0] fmt(input logic [1:0] m,
                                      input logic [11:0] k);
    logic [11:0] f;
    f = (m == MODE_DIFF) ? (k ^ 12'h800) : k;
    return (m == MODE_DIFF) ? {{4{f[11]}}, f} : {4'h0, f};
  endfunction

  // Bounded wait for acquisition to begin; a miss ends the run
  task automatic wait_start;
    int i;
    // The state launched at this edge is only visible a little later
    #1;
    for (i = 0; i < 100 && acq !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (acq !== 1'b1)
    begin
      fails++;
      $display("BAD %0t conversion never started", $time);
      finish_test();
    end
  endtask

  task automatic do_conv(input logic [15:0] c, input logic [11:0] k,
                         input int n, input int a);
    int cyc;
    int ticks;
    wr_reg(CTRL_ADDR, {16'h0, c});
    // Trigger pulses for one cycle, starting as the write lands
    code <= k;
    case (c[2:0])
      3'h0: ext_n <= 1'b0;
      3'h1: tmr1 <= 1'b1;
      3'h2: tmr0 <= 1'b1;
      3'h5: logic_array_trigger <= 1'b1;
      default: ;
    endcase
    @(posedge clk);
    ext_n <= 1'b1;
    tmr0 <= 1'b0;
    tmr1 <= 1'b0;
    logic_array_trigger <= 1'b0;
    wait_start();
    `CHK(active, c[6])
    `CHK(mode, c[4:3])
    `CHK(pwr, 1'b1)
    cyc = 0;
    ticks = 0;
    while ((acq === 1'b1 || conv === 1'b1) && cyc < 5000)
    begin
      if (tick === 1'b1)
        ticks++;
      cyc++;
      @(posedge clk);
      #1;
    end
    `CHK(ticks, a + 19)
    `CHK(cyc, n * (a + 19))
    if (cyc >= 5000)
      finish_test();
    rd_reg(STAT_ADDR, d);
    `CHK(d[2:0], 3'b101)
    rd_reg(DATA_ADDR, d);
    `CHK(d, {fmt(c[4:3], k), 16'h0})
    rd_reg(CTRL_ADDR, d);
    `CHK(d[15:0], (c[2:0] == 3'h3) ? {c[15:3], 3'h0} : c)
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    ext_n = 1'b1;
    logic_array_trigger = 1'b0;
    tmr0 = 1'b0;
    tmr1 = 1'b0;
    code = '0;
    fails = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(CTRL_ADDR, d);
    `CHK(d, 32'h0000_0600)
    rd_reg(CHAN_ADDR, d);
    `CHK(d, 32'h0)
    // Reserved type code with every bit set must not start
    wr_reg(CTRL_ADDR, 32'hffff_ffff);
    rd_reg(CTRL_ADDR, d);
    `CHK(d, 32'h0000_1fff)
    `CHK(acq, 1'b0)
    wr_reg(32'hffff_0508, 32'h1234_5678);
    rd_reg(32'hffff_0508, d);
    `CHK(d, 32'h0)
    // Powered down, then start gate cleared: both refuse
    wr_reg(CTRL_ADDR, 32'h0000_0083);
    repeat (20) @(posedge clk);
    `CHK(acq, 1'b0)
    wr_reg(CTRL_ADDR, 32'h0000_0623);
    repeat (20) @(posedge clk);
    `CHK(acq, 1'b0)
    // Converting before the settling time would give a bad code
    rd_reg(STAT_ADDR, d);
    `CHK(d[2:0], 3'b000)
    for (int i = 0; i < 60 && d[2] !== 1'b1; i++)
    begin
      repeat (10) @(posedge clk);
      rd_reg(STAT_ADDR, d);
    end
    `CHK(d[2], 1'b1)
    if (d[2] !== 1'b1)
      finish_test();
    for (int i = 0; i < 7; i++)
      do_conv(tab_ctl[i], tab_code[i], tab_n[i], tab_a[i]);
    // Temperature channel overrides fast settings; reserved mode 11
    wr_reg(CHAN_ADDR, 32'h10);
    #1;
    `CHK(chan, 5'h10)
    do_conv(16'h00bb, 12'h7ff, 32, 16);
    wr_reg(CHAN_ADDR, 32'h0);
    // Continuous survives a cleared start gate until buffer is full
    code <= 12'h3c3;
    wr_reg(CTRL_ADDR, 32'h0000_00a4);
    wr_reg(CTRL_ADDR, 32'h0000_0024);
    repeat (400) @(posedge clk);
    rd_reg(STAT_ADDR, d);
    `CHK(d[2:0], 3'b101)
    wr_reg(CTRL_ADDR, 32'h0);
    for (int i = 0; i < FIFO_DEPTH; i++)
    begin
      rd_reg(DATA_ADDR, d);
      `CHK(d, 32'h03c3_0000)
    end
    `CHK(ready, 1'b0)
    finish_test();
  end

endmodule
